// file: rtl/core_mem_map.sv
// Core memory map: program counter, fetch path, data space and bank-0 registers
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module core_mem_map
    import core_mem_pkg::*;
#(
    parameter int PROG_WORDS = 8192,
    parameter int GP_WORDS   = 512
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Program counter control from the core
    input  wire pc_op_t            pc_op_i,
    input  wire logic [7:0]        jump_low_i,
    output logic [12:0]            pc_o,
    // Instruction fetch bus
    output fetch_rsp_t             fetch_o,
    // Data bus from the core
    input  wire data_req_t         data_i,
    output logic [7:0]             data_rdata_o,
    output logic                   data_ack_o,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [11:0]       wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    output logic                   wb_err_o
);
    logic [12:0] pc;
    logic [7:0]  sfr [NUM_SFR];
    logic [7:0]  gp_ram [GP_WORDS];
    logic [1:0]  ctrl;
    fetch_req_t  fetch_req;

    // Data-side effective address after indirection
    logic [8:0]  eff_addr;
    logic        eff_null;
    logic        eff_sfr;
    logic [6:0]  eff_ofs;
    logic        eff_pcl;
    logic        eff_latch_upper;
    logic [7:0]  eff_rdata;

    // Wishbone decode
    logic        wb_req;
    logic        wb_in_data;
    logic [8:0]  wb_daddr;
    logic        wb_pc_sel;
    logic        wb_ctrl_sel;
    logic        wb_bad;
    logic        wb_wr_data;

    // Shared write path into the data space
    logic        wr_en;
    logic [8:0]  wr_addr;
    logic [7:0]  wr_data;
    logic [8:0]  rd_addr;
    logic [7:0]  rd_value;

    // Indirect window and banked decode
    function automatic logic [8:0] resolve(input logic [8:0] a, input logic [7:0] ptr,
                                           input logic irp);
        logic [8:0] r;
        r = a;
        if (a[6:0] == OFS_INDIRECT_WINDOW) begin
            r = {irp, ptr};
        end
        return r;
    endfunction

    function automatic logic is_sfr(input logic [8:0] a);
        logic s;
        s = 1'b0;
        if (a[6:0] <= OFS_SHARED_MAX) begin
            s = 1'b1;
        end else if (a[8:7] == 2'b00 && a[6:0] < 7'(NUM_SFR)) begin
            s = 1'b1;
        end
        return s;
    endfunction

    function automatic logic [7:0] read_loc(input logic [8:0] a, input logic [7:0] pcl_v);
        logic [7:0] v;
        v = 8'h00;
        if (a[6:0] == OFS_INDIRECT_WINDOW) begin
            v = 8'h00;
        end else if (is_sfr(a)) begin
            if (a[6:0] == OFS_PC_LOW) begin
                v = pcl_v;
            end else begin
                v = sfr[a[4:0]] & SFR_MASK[a[4:0]];
            end
        end else if (32'(a) < GP_WORDS) begin
            v = gp_ram[a];
        end
        return v;
    endfunction

    // Core data access: window resolved through the indirect pointer
    always_comb begin
        eff_addr = resolve(data_i.addr, sfr[OFS_INDIRECT_PTR[4:0]],
                           sfr[OFS_STATUS[4:0]][STATUS_IRP_BIT]);
        eff_null = (data_i.addr[6:0] == OFS_INDIRECT_WINDOW)
                   && (eff_addr[6:0] == OFS_INDIRECT_WINDOW);
        eff_sfr  = is_sfr(eff_addr);
        eff_ofs  = eff_addr[6:0];
        eff_pcl  = eff_sfr && (eff_ofs == OFS_PC_LOW);
        eff_latch_upper = 1'b0;
        eff_rdata = read_loc(eff_addr, pc[7:0]);
    end

    // Wishbone decode: data space words, then PC and control words
    always_comb begin
        wb_req      = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
        wb_in_data  = (wb_adr_i <= WB_ADDR_TOP);
        wb_daddr    = wb_adr_i[10:2];
        wb_pc_sel   = (wb_adr_i == WB_PC_REG);
        wb_ctrl_sel = (wb_adr_i == WB_CTRL_REG);
        wb_bad      = !(wb_in_data || wb_pc_sel || wb_ctrl_sel) || (wb_adr_i[1:0] != 2'b00);
        wb_wr_data  = wb_req && wb_we_i && wb_in_data && !wb_bad && wb_sel_i[0];
    end

    // Core has priority on the write path; bus writes wait while the core writes
    always_comb begin
        wr_en   = 1'b0;
        wr_addr = eff_addr;
        wr_data = data_i.wdata;
        if (data_i.wr && !eff_null) begin
            wr_en = 1'b1;
        end else if (wb_wr_data && !data_i.wr) begin
            wr_en   = 1'b1;
            wr_addr = wb_daddr;
            wr_data = wb_dat_i[7:0];
        end
    end

    // Register bank and general RAM: static storage, written like data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_SFR; i++) begin
                sfr[i] <= SFR_RESET[i];
            end
        end else if (wr_en && is_sfr(wr_addr) && wr_addr[6:0] != OFS_INDIRECT_WINDOW
                     && wr_addr[6:0] != OFS_PC_LOW) begin
            sfr[wr_addr[4:0]] <= wr_data & SFR_MASK[wr_addr[4:0]];
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr_en && !is_sfr(wr_addr) && 32'(wr_addr) < GP_WORDS) begin
            gp_ram[wr_addr] <= wr_data;
        end
    end

    // Program counter; a latch write alone never moves it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pc <= RESET_VECTOR;
        end else if (data_i.wr && eff_pcl && !eff_null) begin
            pc <= {sfr[OFS_PC_UPPER_LATCH[4:0]][4:0], data_i.wdata};
        end else if (wb_wr_data && !data_i.wr && is_sfr(wb_daddr)
                     && wb_daddr[6:0] == OFS_PC_LOW) begin
            pc <= {sfr[OFS_PC_UPPER_LATCH[4:0]][4:0], wb_dat_i[7:0]};
        end else if (!ctrl[CTRL_HALT_BIT]) begin
            unique case (pc_op_i)
                PC_HOLD: pc <= pc;
                PC_STEP: pc <= pc + 13'h0001;
                PC_JUMP: pc <= {sfr[OFS_PC_UPPER_LATCH[4:0]][4:0], jump_low_i};
                PC_IRQ:  pc <= IRQ_VECTOR;
            endcase
        end
    end

    // Counter value straight from its flip-flops
    always_comb begin
        pc_o = pc;
    end

    // Fetch runs beside the data access every cycle
    always_comb begin
        fetch_req.en   = !rst_i;
        fetch_req.addr = pc;
    end

    program_store #(
        .WORDS (PROG_WORDS)
    ) u_store (
        .clk_i       (clk_i),
        .fetch_i     (fetch_req),
        .small_i     (ctrl[CTRL_VARIANT_4K_BIT]),
        .fetch_o     (fetch_o),
        .load_i      (1'b0),
        .load_addr_i (13'h0000),
        .load_data_i (14'h0000)
    );

    // Core data answer, registered one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_rdata_o <= 8'h00;
            data_ack_o   <= 1'b0;
        end else begin
            data_ack_o <= data_i.rd || data_i.wr;
            if (data_i.rd) begin
                data_rdata_o <= eff_null ? 8'h00 : eff_rdata;
            end
        end
    end

    // Control word: variant select and program counter halt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= CTRL_RESET;
        end else if (wb_req && wb_we_i && wb_ctrl_sel && !wb_bad && wb_sel_i[0]) begin
            ctrl <= wb_dat_i[1:0];
        end
    end

    // Bus read mux; window reads through the bus are not indirected
    always_comb begin
        rd_addr  = wb_daddr;
        rd_value = read_loc(rd_addr, pc[7:0]);
    end

    // Wishbone answer: one cycle after the request is seen; a bus write first waits out a core write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            if (wb_req && !(wb_wr_data && data_i.wr)) begin
                if (wb_bad) begin
                    wb_err_o <= 1'b1;
                end else begin
                    wb_ack_o <= 1'b1;
                    if (wb_pc_sel) begin
                        wb_dat_o <= {19'h00000, pc};
                    end else if (wb_ctrl_sel) begin
                        wb_dat_o <= {30'h00000000, ctrl};
                    end else begin
                        wb_dat_o <= {24'h000000, rd_value};
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: rtl/core_mem_pkg.sv
// Package: offsets, field layouts, reset values and carriers of the core memory block
package core_mem_pkg;

    localparam int          PC_WIDTH        = 13;
    localparam int          INSN_WIDTH      = 14;
    localparam int          DATA_WIDTH      = 8;
    localparam int          DADDR_WIDTH     = 9;
    localparam int          LATCH_WIDTH     = 5;

    localparam logic [12:0] RESET_VECTOR    = 13'h0000;
    localparam logic [12:0] IRQ_VECTOR      = 13'h0004;

    // Bank-0 map offsets
    localparam logic [6:0]  OFS_INDIRECT_WINDOW = 7'h00;
    localparam logic [6:0]  OFS_TIMER0_COUNT    = 7'h01;
    localparam logic [6:0]  OFS_PC_LOW          = 7'h02;
    localparam logic [6:0]  OFS_STATUS          = 7'h03;
    localparam logic [6:0]  OFS_INDIRECT_PTR    = 7'h04;
    localparam logic [6:0]  OFS_PORT_A          = 7'h05;
    localparam logic [6:0]  OFS_PORT_B          = 7'h06;
    localparam logic [6:0]  OFS_PORT_C          = 7'h07;
    localparam logic [6:0]  OFS_PORT_D          = 7'h08;
    localparam logic [6:0]  OFS_PORT_E          = 7'h09;
    localparam logic [6:0]  OFS_PC_UPPER_LATCH  = 7'h0A;
    localparam logic [6:0]  OFS_IRQ_CONTROL     = 7'h0B;
    localparam logic [6:0]  OFS_IRQ_FLAGS_1     = 7'h0C;
    localparam logic [6:0]  OFS_IRQ_FLAGS_2     = 7'h0D;
    localparam logic [6:0]  OFS_TIMER1_LOW      = 7'h0E;
    localparam logic [6:0]  OFS_TIMER1_HIGH     = 7'h0F;
    localparam logic [6:0]  OFS_TIMER1_CONTROL  = 7'h10;
    localparam logic [6:0]  OFS_TIMER2_COUNT    = 7'h11;
    localparam logic [6:0]  OFS_TIMER2_CONTROL  = 7'h12;
    localparam logic [6:0]  OFS_SERIAL_BUFFER   = 7'h13;
    localparam logic [6:0]  OFS_SERIAL_CONTROL  = 7'h14;
    localparam logic [6:0]  OFS_CAPTURE1_LOW    = 7'h15;
    localparam int          NUM_SFR             = 22;

    // Offsets mirrored in every bank
    localparam logic [6:0]  OFS_SHARED_MAX      = 7'h0B;

    // Implemented-bit masks per offset (unimplemented bits read zero)
    localparam logic [7:0]  SFR_MASK [NUM_SFR] = '{
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF,
        8'hFF, 8'h07, 8'h1F, 8'hFF, 8'hFF, 8'h19, 8'hFF, 8'hFF,
        8'h3F, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF};

    // Reset values per offset
    localparam logic [7:0]  SFR_RESET [NUM_SFR] = '{
        8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    // Status register fields
    localparam int          STATUS_IRP_BIT  = 7;
    localparam int          STATUS_RP1_BIT  = 6;
    localparam int          STATUS_RP0_BIT  = 5;

    // Wishbone byte addresses of the block's own registers
    localparam logic [11:0] WB_DATA_BASE    = 12'h000;
    localparam logic [11:0] WB_PC_REG       = 12'h800;
    localparam logic [11:0] WB_CTRL_REG     = 12'h804;
    localparam logic [11:0] WB_ADDR_TOP     = 12'h7FC;

    // Control register fields
    localparam int          CTRL_VARIANT_4K_BIT = 0;
    localparam int          CTRL_HALT_BIT       = 1;
    localparam logic [1:0]  CTRL_RESET          = 2'h3;

    typedef struct packed {
        logic        en;
        logic [12:0] addr;
    } fetch_req_t;

    typedef struct packed {
        logic        valid;
        logic [13:0] insn;
    } fetch_rsp_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [8:0]  addr;
        logic [7:0]  wdata;
    } data_req_t;

    typedef enum logic [1:0] {
        PC_HOLD   = 2'b00,
        PC_STEP   = 2'b01,
        PC_JUMP   = 2'b10,
        PC_IRQ    = 2'b11
    } pc_op_t;

endpackage

// file: rtl/program_store.sv
// Program store: 14-bit words addressed by the program counter with wraparound
`timescale 1ns/1ps
`default_nettype none
module program_store
    import core_mem_pkg::*;
#(
    parameter int WORDS = 8192
) (
    // Clock; the store has no reset
    input  wire logic              clk_i,
    // Fetch port
    input  wire fetch_req_t        fetch_i,
    input  wire logic              small_i,
    output fetch_rsp_t             fetch_o,
    // Load port
    input  wire logic              load_i,
    input  wire logic [12:0]       load_addr_i,
    input  wire logic [13:0]       load_data_i
);
    logic [13:0] mem [WORDS];
    logic [12:0] fetch_addr;

    // Upper address bit dropped on the small variant
    always_comb begin
        fetch_addr = fetch_i.addr;
        if (small_i) begin
            fetch_addr[12] = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (load_i) begin
            mem[load_addr_i] <= load_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        fetch_o.valid <= fetch_i.en;
        fetch_o.insn  <= mem[fetch_addr];
    end
endmodule
`default_nettype wire

// file: verif/core_mem_map_sva.sv
// Concurrent checks on the core memory map ports
`timescale 1ns/1ps
`default_nettype none
module core_mem_map_sva
    import core_mem_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Observed ports
    input  wire logic [12:0] pc_o,
    input  wire fetch_rsp_t  fetch_o,
    input  wire data_req_t   data_i,
    input  wire logic        data_ack_o,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    input  wire logic        wb_err_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_WB_ANSWER: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |-> ##[1:4] (wb_ack_o || wb_err_o))
        else $error("bus request not answered");
    AST_WB_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    AST_WB_ERR_PULSE: assert property (wb_err_o |=> !wb_err_o)
        else $error("err held too long");
    AST_WB_CAUSE: assert property (
        (wb_ack_o || wb_err_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("bus answer without request");
    AST_UPPER_ZERO: assert property (
        wb_ack_o && !wb_adr_i[11] |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    AST_DATA_ACK: assert property ((data_i.rd || data_i.wr) |=> data_ack_o)
        else $error("data access not acknowledged");
    AST_DATA_CAUSE: assert property (data_ack_o |-> $past(data_i.rd || data_i.wr))
        else $error("data ack without access");
    AST_FETCH_CONC: assert property (
        (data_i.rd || data_i.wr) && !$past(rst_i) |=> fetch_o.valid)
        else $error("fetch stalled by data access");
    AST_RESET_QUIET: assert property (
        $past(rst_i) |-> !wb_ack_o && !wb_err_o && !data_ack_o && wb_dat_o == 32'h0)
        else $error("outputs busy after reset");
    AST_PC_RESET: assert property ($past(rst_i) |-> pc_o == 13'h0000)
        else $error("program counter not zero after reset");
endmodule
bind core_mem_map core_mem_map_sva u_core_mem_map_sva (.clk_i(clk_i), .rst_i(rst_i),
    .pc_o(pc_o),
    .fetch_o(fetch_o), .data_i(data_i), .data_ack_o(data_ack_o), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o));
`default_nettype wire

// file: verif/core_side_model.sv
// Processor core model: program counter control and data bus requests
`timescale 1ns/1ps
`default_nettype none
module core_side_model
    import core_mem_pkg::*;
(
    // Clock
    input  wire logic       clk_i,
    // Data bus answers
    input  wire logic       data_ack_i,
    input  wire logic [7:0] data_rdata_i,
    // Requests to the block
    output var pc_op_t      pc_op_o,
    output logic [7:0]      jump_low_o,
    output var data_req_t   data_o
);
    initial begin
        pc_op_o = PC_HOLD;
        jump_low_o = 8'h00;
        data_o = '0;
    end
    task automatic access(input logic w, input logic [8:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        data_o <= '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge clk_i);
        // Idle bus shows inverted values, not the last ones
        data_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        do begin
            @(posedge clk_i);
            n++;
        end while (!data_ack_i && n < 20);
        q = data_rdata_i;
    endtask
    task automatic pc_cmd(input pc_op_t op, input logic [7:0] lo);
        @(posedge clk_i);
        pc_op_o <= op;
        jump_low_o <= lo;
        @(posedge clk_i);
        pc_op_o <= PC_HOLD;
        jump_low_o <= ~lo;
    endtask
endmodule
`default_nettype wire

// file: verif/tb_core_memory_map_and_sfr_bank0.sv
// Self-checking bench for the core memory map
`timescale 1ns/1ps
`default_nettype none
module tb_core_memory_map_and_sfr_bank0;
    import core_mem_pkg::*;
    typedef struct packed {
        logic [11:0] wa;
        logic [11:0] ra;
        logic [7:0]  wd;
        logic [7:0]  exp;
    } row_t;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    pc_op_t      pc_op;
    logic [7:0]  jump_low;
    data_req_t   data_req;
    logic [7:0]  data_rdata;
    logic        data_ack;
    fetch_rsp_t  fetch;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [11:0] adr = 12'h000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] wb_q;
    logic        ack;
    logic        err;
    logic [31:0] q;
    logic        e;
    logic [7:0]  b;
    logic [12:0] pc;
    int          num_errors = 0;
    int          num_checks = 0;
    logic [6:0]  rst_ofs [8] = '{7'h02, 7'h03, 7'h0A, 7'h0C, 7'h10, 7'h11, 7'h12, 7'h14};
    row_t        rows [8] = '{'{12'h014, 12'h014, 8'hFF, 8'h3F}, '{12'h024, 12'h024, 8'hFF, 8'h07},
        '{12'h034, 12'h034, 8'hFF, 8'h19}, '{12'h048, 12'h048, 8'hFF, 8'h7F},
        '{12'h028, 12'h228, 8'hFF, 8'h1F}, '{12'h22C, 12'h02C, 8'h5A, 8'h5A},
        '{12'h080, 12'h080, 8'hC3, 8'hC3}, '{12'h000, 12'h000, 8'h77, 8'h00}};
    core_mem_map u_core_mem_map (.clk_i(clk_i), .rst_i(rst_i), .pc_op_i(pc_op),
        .jump_low_i(jump_low), .pc_o(pc), .fetch_o(fetch), .data_i(data_req),
        .data_rdata_o(data_rdata), .data_ack_o(data_ack), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_q),
        .wb_ack_o(ack), .wb_err_o(err));
    core_side_model u_core_side_model (.clk_i(clk_i), .data_ack_i(data_ack),
        .data_rdata_i(data_rdata), .pc_op_o(pc_op), .jump_low_o(jump_low), .data_o(data_req));
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (!ack && !err && n < 50);
        q = wb_q;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(WB_PC_REG, 32'h0);
        rd(WB_CTRL_REG, {30'h0, CTRL_RESET});
        foreach (rst_ofs[i]) rd({3'h0, rst_ofs[i], 2'h0}, {24'h0, SFR_RESET[rst_ofs[i]]});
        foreach (rows[i]) begin
            wb(1'b1, rows[i].wa, {24'hFFFFFF, rows[i].wd});
            rd(rows[i].ra, {24'h0, rows[i].exp});
        end
        wb(1'b0, 12'h808, 32'h0);
        chk({31'h0, e}, 32'h1);
        wb(1'b1, 12'h002, 32'h0);
        chk({31'h0, e}, 32'h1);
        // Indirect write lands on the pointed location
        wb(1'b1, 12'h010, 32'h21);
        u_core_side_model.access(1'b1, 9'h000, 8'h3C, b);
        rd(12'h084, 32'h3C);
        u_core_side_model.access(1'b0, 9'h000, 8'h00, b);
        chk({24'h0, b}, 32'h3C);
        wb(1'b1, 12'h010, 32'h0);
        u_core_side_model.access(1'b1, 9'h000, 8'h55, b);
        u_core_side_model.access(1'b0, 9'h000, 8'h00, b);
        chk({24'h0, b}, 32'h0);
        fork
            u_core_side_model.access(1'b1, 9'h030, 8'h99, b);
            rd(12'h080, 32'hC3);
        join
        rd(12'h0C0, 32'h99);
        wb(1'b1, WB_CTRL_REG, 32'h0);
        u_core_side_model.access(1'b1, 9'h00A, 8'h15, b);
        rd(WB_PC_REG, 32'h0);
        u_core_side_model.pc_cmd(PC_JUMP, 8'h34);
        rd(WB_PC_REG, 32'h1534);
        u_core_side_model.pc_cmd(PC_IRQ, 8'h00);
        rd(WB_PC_REG, {19'h0, IRQ_VECTOR});
        u_core_side_model.access(1'b1, 9'h00A, 8'hFF, b);
        u_core_side_model.pc_cmd(PC_JUMP, 8'hFF);
        rd(WB_PC_REG, 32'h1FFF);
        u_core_side_model.pc_cmd(PC_STEP, 8'h00);
        rd(WB_PC_REG, 32'h0);
        chk({19'h0, pc}, 32'h0);
        u_core_side_model.access(1'b1, 9'h002, 8'h40, b);
        rd(WB_PC_REG, 32'h1F40);
        conclude();
    end
endmodule
`default_nettype wire
